// ### verilog/bss_top.sv
// Start-up sequencer of a step-down converter: POR, enable, delay, sample, ramp.
// Assumes comparator outputs arrive synchronous to clk; analog lives outside.
`default_nettype none

// Function
// [RULE_01] After bias rises past its threshold, proceed to delay then set-point sampling.
// [RULE_02] Hold off all initialization while enable pin stays low.
// [RULE_03] Keep enable pull-up on; timing starts only once pin crosses trip.
// [RULE_04] Wait fixed 6.8 ms delay after enable crosses trip.
// [RULE_05] During delay, low-side driver off, set current source on.
// [RULE_06] Sample phase variable, up to 3.4 ms, longer for higher setting.
// [RULE_07] Hold sampled set point in counter while bias stays up.
// [RULE_08] Sample completion starts soft-start.
// [RULE_09] Ramp reference from zero to final over 6.8 ms.
// [RULE_10] Ramp is 64 equal digital steps, not adjustable.
// [RULE_11] Enable error amplifier after short interval into soft-start.
// [RULE_12] Soft-start ends when ramp exceeds final value; then regulate.
// [RULE_13] Output pre-biased low: switches off until ramp passes output.
// [RULE_14] Output pre-biased high: switches off until soft-start ends.
// [RULE_15] Enable low then released repeats full initialization with new sample.
// [RULE_16] Overcurrent retries reuse held set point, no new sample.
// [RULE_17] Outside logic may hold enable low until input supply ready.
// [RULE_18] Overcurrent: output off, two dummy soft-starts, one real, repeat.
// [RULE_19] Enable pin below disable threshold counts as disabled.
// [RULE_20] Timing counts clock cycles; phases run reset, delay, sample, ramp, regulate.
module bss_top #(
  parameter int DELAY_CYCLES = bss_pkg::DELAY_CYC,
  parameter int SAMPLE_MAX_CYCLES = bss_pkg::SAMPLE_MAX_CYC,
  parameter int STEP_CYCLES = bss_pkg::SS_STEP_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire bss_pkg::bss_sense_s sense,
  output bss_pkg::bss_drive_s drive,
  output logic [bss_pkg::REF_W-1:0] ref_code,
  output logic [bss_pkg::SET_W-1:0] set_code,
  output logic [2:0] phase
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1_r;
  logic rst_b_r;

  // Two-stage release so reset leaves all other flops in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_b_r <= rst_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // State and counters
  // ----------------------------------------------------------------
  bss_pkg::bss_state_e state_r, state_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [31:0] samp_r, samp_nxt;
  logic [bss_pkg::REF_W-1:0] ramp_r, ramp_nxt;
  logic [bss_pkg::SET_W-1:0] set_r, set_nxt;
  logic [1:0] dummy_r, dummy_nxt;
  logic dummy_run_r, dummy_run_nxt;
  logic ramp_seen_r, ramp_seen_nxt;
  bss_pkg::bss_drive_s drive_nxt;

  // ----------------------------------------------------------------
  // Sense decode
  // ----------------------------------------------------------------
  // Window bound uses its own timer, since the step counter restarts on every code
  wire logic enabled = sense.bias_above & sense.en_above; // RULE_02
  wire logic delay_done = (cnt_r >= 32'(DELAY_CYCLES - 1)); // RULE_04
  wire logic step_tick = (cnt_r >= 32'(STEP_CYCLES - 1)); // RULE_10
  wire logic sample_done = sense.set_match | (samp_r >= 32'(SAMPLE_MAX_CYCLES - 1)) // RULE_06
    | (set_r == {bss_pkg::SET_W{1'b1}});
  wire logic ramp_full = (ramp_r >= bss_pkg::REF_FINAL); // RULE_12

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next-state sequencing; strict phase order with retry loop
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 32'h00000001;
    samp_nxt = 32'h00000000;
    ramp_nxt = ramp_r;
    set_nxt = set_r;
    dummy_nxt = dummy_r;
    dummy_run_nxt = dummy_run_r;
    ramp_seen_nxt = ramp_seen_r;
    case (state_r)
      bss_pkg::BSS_RESET: begin
        cnt_nxt = 32'h00000000;
        if (enabled) begin // RULE_01 RULE_03
          state_nxt = bss_pkg::BSS_DELAY; // RULE_20
        end
      end
      bss_pkg::BSS_DELAY: begin
        if (delay_done) begin
          state_nxt = bss_pkg::BSS_SAMPLE;
          cnt_nxt = 32'h00000000;
          set_nxt = bss_pkg::SET_RST; // RULE_15
        end
      end
      bss_pkg::BSS_SAMPLE: begin
        // Counter climbs until the DAC meets the resistor voltage, the window ends or the code is full
        samp_nxt = samp_r + 32'h00000001; // RULE_06
        if (sample_done) begin // RULE_08
          state_nxt = bss_pkg::BSS_SOFT;
          cnt_nxt = 32'h00000000;
          ramp_nxt = '0;
          ramp_seen_nxt = 1'b0;
          dummy_run_nxt = 1'b0;
        end else if (step_tick) begin
          set_nxt = set_r + 8'h01; // RULE_06
          cnt_nxt = 32'h00000000;
        end
      end
      bss_pkg::BSS_SOFT: begin
        if (sense.ramp_above_out) begin
          ramp_seen_nxt = 1'b1; // RULE_13
        end
        if (step_tick) begin
          cnt_nxt = 32'h00000000;
          if (ramp_full) begin // RULE_12
            if (dummy_run_r) begin
              dummy_nxt = dummy_r - 2'h1; // RULE_18
              ramp_nxt = '0;
              dummy_run_nxt = (dummy_r != 2'h1);
              ramp_seen_nxt = 1'b0; // RULE_13
            end else begin
              state_nxt = bss_pkg::BSS_REG;
            end
          end else begin
            ramp_nxt = ramp_r + 7'h01; // RULE_09 RULE_10
          end
        end
        if (sense.overcurrent && !dummy_run_r) begin
          state_nxt = bss_pkg::BSS_HICCUP; // RULE_18
        end
      end
      bss_pkg::BSS_REG: begin
        if (sense.overcurrent) begin
          state_nxt = bss_pkg::BSS_HICCUP; // RULE_18
        end
      end
      bss_pkg::BSS_HICCUP: begin
        // Retry keeps the held set point
        state_nxt = bss_pkg::BSS_SOFT; // RULE_16
        cnt_nxt = 32'h00000000;
        ramp_nxt = '0;
        ramp_seen_nxt = 1'b0;
        dummy_nxt = 2'(bss_pkg::HICCUP_DUMMIES);
        dummy_run_nxt = 1'b1;
      end
      default: begin
        state_nxt = bss_pkg::BSS_RESET;
      end
    endcase
    // Disable or loss of bias restarts the sequence from reset
    if (!enabled) begin // RULE_15 RULE_19 RULE_17
      state_nxt = bss_pkg::BSS_RESET;
      cnt_nxt = 32'h00000000;
      ramp_nxt = '0;
      dummy_run_nxt = 1'b0;
    end
    if (!sense.bias_above) begin
      set_nxt = bss_pkg::SET_RST; // RULE_07
    end
  end

  // ----------------------------------------------------------------
  // Output decode
  // ----------------------------------------------------------------
  // Output decode from next state so outputs are registered
  wire logic nx_soft = (state_nxt == bss_pkg::BSS_SOFT);
  wire logic nx_reg = (state_nxt == bss_pkg::BSS_REG);
  wire logic nx_live = nx_soft & !dummy_run_nxt;
  wire logic sw_ok = nx_reg | (nx_live & ramp_seen_nxt & !sense.out_above_ref); // RULE_13 RULE_14
  always_comb begin
    drive_nxt.en_pullup = 1'b1; // RULE_03
    drive_nxt.set_src_on = (state_nxt == bss_pkg::BSS_DELAY) | (state_nxt == bss_pkg::BSS_SAMPLE); // RULE_05
    drive_nxt.low_gate_en = sw_ok;
    drive_nxt.high_gate_en = sw_ok;
    drive_nxt.ea_en = nx_reg | (nx_live & (ramp_nxt >= 7'(bss_pkg::EA_INIT_STEPS))); // RULE_11
    drive_nxt.ss_done = nx_reg; // RULE_12
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // Phase register
  always_ff @(posedge clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      state_r <= bss_pkg::BSS_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Phase and step timer
  always_ff @(posedge clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      cnt_r <= 32'h00000000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Sample window timer
  always_ff @(posedge clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      samp_r <= 32'h00000000;
    end else begin
      samp_r <= samp_nxt;
    end
  end

  // Ramp code
  always_ff @(posedge clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      ramp_r <= '0;
    end else begin
      ramp_r <= ramp_nxt;
    end
  end

  // Held set point, kept while bias stays up until a new sample phase starts
  always_ff @(posedge clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      set_r <= bss_pkg::SET_RST;
    end else begin
      set_r <= set_nxt; // RULE_07
    end
  end

  // Dummy ramps left in a retry
  always_ff @(posedge clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      dummy_r <= 2'h0;
    end else begin
      dummy_r <= dummy_nxt;
    end
  end

  // Dummy ramp in progress
  always_ff @(posedge clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      dummy_run_r <= 1'b0;
    end else begin
      dummy_run_r <= dummy_run_nxt;
    end
  end

  // Ramp has passed the output in this run
  always_ff @(posedge clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      ramp_seen_r <= 1'b0;
    end else begin
      ramp_seen_r <= ramp_seen_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Drive bundle
  always_ff @(posedge clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      drive <= '0;
    end else begin
      drive <= drive_nxt;
    end
  end

  // Reference code seen by the DAC
  always_ff @(posedge clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      ref_code <= '0;
    end else begin
      ref_code <= ramp_nxt;
    end
  end

  // Set-point code seen by the trip DAC
  always_ff @(posedge clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      set_code <= bss_pkg::SET_RST;
    end else begin
      set_code <= set_nxt;
    end
  end

  // Phase report
  always_ff @(posedge clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      phase <= 3'h0;
    end else begin
      phase <= 3'(state_nxt);
    end
  end

endmodule // bss_top

`default_nettype wire

// ### verilog/bss_pkg.sv
// Package for the buck start-up sequencer: timing, widths and carriers.
// Assumes a 50 MHz system clock standing in for the internal oscillator.
`default_nettype none

package bss_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int DELAY_US = 6800;                // Start-up delay, 6.8 ms
  localparam int DELAY_CYC = DELAY_US * (CLK_HZ / 1000000);
  localparam int SAMPLE_MAX_US = 3400;           // Sample phase upper bound, 3.4 ms
  localparam int SAMPLE_MAX_CYC = SAMPLE_MAX_US * (CLK_HZ / 1000000);
  localparam int SS_US = 6800;                   // Soft-start ramp, 6.8 ms
  localparam int SS_STEPS = 64;                  // Discrete ramp steps
  localparam int SS_STEP_CYC = (SS_US * (CLK_HZ / 1000000)) / SS_STEPS;
  localparam int EA_INIT_STEPS = 2;              // Steps before error amp is enabled
  localparam int HICCUP_DUMMIES = 2;             // Dummy soft-starts per retry

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int SET_W = 8;                      // Set-point code width
  localparam int REF_W = 7;                      // Reference code, 0..64
  localparam logic [REF_W-1:0] REF_FINAL = 7'h40; // Full-scale reference code
  localparam logic [SET_W-1:0] SET_RST = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BSS_RESET, BSS_DELAY, BSS_SAMPLE, BSS_SOFT, BSS_REG, BSS_HICCUP
  } bss_state_e;

  // Analog sense inputs, already digitised by comparators
  typedef struct packed {
    logic bias_above;      // Bias supply over its rising threshold
    logic en_above;        // Enable pin over its disable trip level
    logic set_match;       // DAC has reached the set-resistor voltage
    logic ramp_above_out;  // Ramp has crossed the present output
    logic out_above_ref;   // Output sits above target
    logic overcurrent;     // Overcurrent detected
  } bss_sense_s;

  // Drive outputs to the power stage and analog blocks
  typedef struct packed {
    logic en_pullup;       // Internal pull-up source on the enable pin
    logic set_src_on;      // Fixed current into the set resistor
    logic low_gate_en;     // Low-side driver permitted
    logic high_gate_en;    // High-side driver permitted
    logic ea_en;           // Error amplifier enabled
    logic ss_done;         // Soft-start finished, regulating
  } bss_drive_s;

endpackage : bss_pkg

`default_nettype wire

// ### dv/bss_assertions.sv
// Concurrent checks on the start-up sequencer ports, bound into bss_top.
// Assumes sense arrives synchronous to clk and rst_b is the raw reset pin.
`default_nettype none
module bss_assertions #(
  parameter int DELAY_CYCLES = 20,
  parameter int SAMPLE_MAX_CYCLES = 50,
  parameter int STEP_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire bss_pkg::bss_sense_s sense,
  input wire bss_pkg::bss_drive_s drive,
  input wire logic [bss_pkg::REF_W-1:0] ref_code,
  input wire logic [bss_pkg::SET_W-1:0] set_code,
  input wire logic [2:0] phase
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Delay length counter
  // ----------------------------------------------------------------
  logic [19:0] dly_r;
  // Counter avoids a long repetition the tools would unroll
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) dly_r <= '0;
    else dly_r <= (phase == 3'h1) ? dly_r + 20'h1 : 20'h0;
  end
  logic [19:0] smp_r;
  // Sample window length, counted the same way
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) smp_r <= '0;
    else smp_r <= (phase == 3'h2) ? smp_r + 20'h1 : 20'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_bias_loss_reset: assert property (!sense.bias_above |=> phase == 3'h0)
    else $error("bias loss did not park sequencer");
  chk_en_low_off: assert property (!sense.en_above |=> phase == 3'h0 && !drive.high_gate_en)
    else $error("low enable did not park sequencer");
  chk_delay_len: assert property (phase == 3'h2 && $past(phase) == 3'h1 |->
    dly_r >= DELAY_CYCLES - 1 && dly_r <= DELAY_CYCLES + 1)
    else $error("start-up delay length wrong");
  chk_delay_drive: assert property (phase == 3'h1 |-> drive.set_src_on && !drive.low_gate_en)
    else $error("delay phase drive wrong");
  chk_sample_len: assert property (phase == 3'h2 |-> smp_r < SAMPLE_MAX_CYCLES)
    else $error("sample window too long");
  chk_set_held: assert property (phase >= 3'h3 && $past(phase) >= 3'h3 |-> $stable(set_code))
    else $error("held set point moved");
  chk_ref_steps: assert property (phase == 3'h3 && ref_code != $past(ref_code) |->
    ref_code == $past(ref_code) + 7'h1 || ref_code == 7'h0)
    else $error("ramp step not single");
  chk_ea_late: assert property ($rose(drive.ea_en) |-> phase == 3'h3 && ref_code >= 7'h2)
    else $error("error amp enabled too early");
  chk_done_full: assert property ($rose(drive.ss_done) |->
    phase == 3'h4 && $past(ref_code) == bss_pkg::REF_FINAL)
    else $error("ramp ended short of full scale");
  chk_prebias_lo: assert property (phase == 3'h3 && !sense.ramp_above_out ##1 phase == 3'h3 |->
    !drive.high_gate_en && !drive.low_gate_en)
    else $error("switches on below output");
  chk_prebias_hi: assert property (phase == 3'h3 && sense.out_above_ref ##1 phase == 3'h3 |->
    !drive.high_gate_en && !drive.low_gate_en)
    else $error("switches on with high output");
  chk_phase_order: assert property (phase != $past(phase) |-> phase == 3'h0 ||
    phase == $past(phase) + 3'h1 || phase == 3'h5 || ($past(phase) == 3'h5 && phase == 3'h3))
    else $error("illegal phase order");
endmodule // bss_assertions
bind bss_top bss_assertions #(.DELAY_CYCLES(DELAY_CYCLES), .SAMPLE_MAX_CYCLES(SAMPLE_MAX_CYCLES),
  .STEP_CYCLES(STEP_CYCLES)) u_chk (.clk(clk), .rst_b(rst_b), .sense(sense), .drive(drive),
  .ref_code(ref_code), .set_code(set_code), .phase(phase));
`default_nettype wire

// ### dv/bss_far_model.sv
// Supplies, enable logic and set resistor seen from the sequencer.
// Assumes the bench steers supply, enable and fault requests.
`default_nettype none
module bss_far_model (
  input wire logic bias_on,
  input wire logic en_free,
  input wire logic [7:0] set_lvl,
  input wire logic [6:0] pre_lvl,
  input wire logic oc_req,
  input wire bss_pkg::bss_drive_s drive,
  input wire logic [bss_pkg::REF_W-1:0] ref_code,
  input wire logic [bss_pkg::SET_W-1:0] set_code,
  output bss_pkg::bss_sense_s sense
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin only rises when released and the pull-up is sourcing
  assign sense.bias_above = bias_on;
  assign sense.en_above = bias_on & en_free & drive.en_pullup;
  // Set voltage only builds while the fixed current flows
  assign sense.set_match = drive.set_src_on & (set_code >= set_lvl);
  assign sense.ramp_above_out = ref_code > pre_lvl;
  assign sense.out_above_ref = pre_lvl > bss_pkg::REF_FINAL;
  assign sense.overcurrent = oc_req;
endmodule // bss_far_model
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for bss_top with shortened counts.
// Assumes bss_far_model stands for supplies and enable logic.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, bias_on, en_free, oc_req;
  logic [7:0] set_lvl, held;
  logic [6:0] pre_lvl;
  logic [15:0] lfsr;
  bss_pkg::bss_sense_s sense;
  bss_pkg::bss_drive_s drive;
  logic [6:0] ref_code;
  logic [7:0] set_code;
  logic [2:0] phase;
  int n_errors, cmp_count, cyc, n, i;
  int samp[5];
  bss_top #(.DELAY_CYCLES(20), .SAMPLE_MAX_CYCLES(200), .STEP_CYCLES(4)) uut (.clk(clk), .rst_b(rst_b),
    .sense(sense), .drive(drive), .ref_code(ref_code), .set_code(set_code), .phase(phase));
  bss_far_model far (.bias_on(bias_on), .en_free(en_free), .set_lvl(set_lvl), .pre_lvl(pre_lvl),
    .oc_req(oc_req), .drive(drive), .ref_code(ref_code), .set_code(set_code), .sense(sense));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Loose window: exact latency at phase edges is the design's choice
  function automatic logic [7:0] in_rng(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi) ? 8'h01 : 8'h00;
  endfunction
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_phase(input logic [2:0] p, output int cnt);
    cnt = 0;
    while (phase !== p && cnt < 2000) begin
      @(negedge clk);
      cnt++;
    end
    check_val({5'h0, phase}, {5'h0, p});
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard, far above the few thousand cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0; bias_on = 1'b0; en_free = 1'b0; oc_req = 1'b0;
    set_lvl = 8'h05; pre_lvl = 7'h00; lfsr = 16'h4A82;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    bias_on = 1'b1;
    repeat (30) @(negedge clk);
    check_val({5'h0, phase}, 8'h00);
    // Last pass asks for more codes than the sample window allows
    for (i = 0; i < 5; i++) begin
      lfsr = lfsr_next(lfsr);
      set_lvl = (i == 0) ? 8'h01 : (i == 1) ? 8'h28 : (i == 4) ? 8'h80 : {3'h0, lfsr[4:0]} + 8'h01;
      pre_lvl = (i == 2) ? 7'h14 : (i == 3) ? 7'h46 : 7'h00;
      en_free = 1'b1;
      wait_phase(3'h2, n);
      wait_phase(3'h3, samp[i]);
      check_val(in_rng(samp[i], 0, 200), 8'h01);
      if (i == 4) check_val(in_rng(set_code, 45, 50), 8'h01);
      else check_val(set_code, set_lvl);
      wait_phase(3'h4, n);
      check_val(in_rng(n, 256, 264), 8'h01);
      check_val({1'b0, ref_code}, 8'h40);
      check_val({7'h0, drive.ea_en}, 8'h01);
      repeat (2) @(negedge clk);
      check_val({7'h0, drive.low_gate_en}, 8'h01);
      en_free = (i == 4);
      repeat (2) @(negedge clk);
      if (i < 4) check_val({5'h0, phase}, 8'h00);
    end
    check_val(in_rng(samp[1] - samp[0], 100, 200), 8'h01);
    // Fault retry must reuse the held set point
    held = set_code;
    set_lvl = held + 8'h03;
    oc_req = 1'b1;
    @(negedge clk);
    oc_req = 1'b0;
    wait_phase(3'h5, n);
    wait_phase(3'h4, n);
    check_val(in_rng(n, 760, 800), 8'h01);
    check_val(set_code, held);
    bias_on = 1'b0;
    repeat (3) @(negedge clk);
    check_val({5'h0, phase}, 8'h00);
    check_val(set_code, 8'h00);
    complete_run();
  end
endmodule // tb
`default_nettype wire
